//--- verilog/oxygen_control_pkg.sv
// Purpose: Shared constants and types for the oxygen alarm and range control block.
// Assumes: Concentration is carried in hundredths of a percent oxygen (2500 = 25.00 %).
// Notes:   DAC codes are 12 bit, full code 4095 equals 10 V or 20 mA.
package oxygen_control_pkg;

   // Clock and timing
   localparam int unsigned CLOCK_HZ          = 25000000;
   localparam int unsigned ADJUST_WINDOW_S   = 5;
   localparam int unsigned ALARM_INHIBIT_S   = 25;
   localparam int unsigned BLINK_HALF_MS     = 500;
   localparam int unsigned ADJUST_WINDOW_CYC = ADJUST_WINDOW_S * CLOCK_HZ;
   localparam int unsigned ALARM_INHIBIT_CYC = ALARM_INHIBIT_S * CLOCK_HZ;
   localparam int unsigned BLINK_HALF_CYC    = BLINK_HALF_MS * (CLOCK_HZ / 1000);

   // Concentration limits, hundredths of a percent
   localparam logic [11:0] CONC_MIN_SET      = 12'h064;  // 1.00 %
   localparam logic [11:0] CONC_MAX_SET      = 12'h9C4;  // 25.00 %
   localparam logic [11:0] SENSOR_FAIL_LEVEL = 12'h005;  // 0.05 %
   localparam logic [7:0]  RETURN_PERCENT    = 8'h55;    // 85 % of narrow full scale
   localparam logic [7:0]  HUNDRED_PERCENT   = 8'h64;

   // DAC codes
   localparam logic [11:0] DAC_FULL          = 12'hFFF;  // 10 V or 20 mA
   localparam logic [11:0] DAC_LOOP_ZERO     = 12'h333;  // 4 mA
   localparam logic [11:0] DAC_LOOP_SPAN     = 12'hCCC;  // 16 mA of swing
   localparam logic [11:0] RANGE_IDENTITY_OUTPUT_NARROW   = 12'h555;  // 3.33 V
   localparam logic [11:0] RANGE_IDENTITY_OUTPUT_WIDE     = 12'hAAA;  // 6.66 V
   localparam logic [11:0] RANGE_IDENTITY_OUTPUT_AIR_CAL  = 12'hFFF;  // 10 V

   // Span gain, unity at 2048
   localparam logic [11:0] SPAN_UNITY        = 12'h800;
   localparam int unsigned SPAN_SHIFT        = 11;

   // Reset values
   localparam logic [11:0] UPPER_ALARM_RESET = 12'h7D0;  // 20.00 %
   localparam logic [11:0] LOWER_ALARM_RESET = 12'h4B0;  // 12.00 %
   localparam logic [11:0] WIDE_FS_RESET     = 12'h9C4;  // 25.00 %
   localparam logic [11:0] NARROW_FS_RESET   = 12'h3E8;  // 10.00 %

   // APB register byte offsets
   localparam logic [7:0] STATUS_OFFSET      = 8'h00;
   localparam logic [7:0] UPPER_ALARM_OFFSET = 8'h04;
   localparam logic [7:0] LOWER_ALARM_OFFSET = 8'h08;
   localparam logic [7:0] WIDE_FS_OFFSET     = 8'h0C;
   localparam logic [7:0] NARROW_FS_OFFSET   = 8'h10;
   localparam logic [7:0] RANGE_MODE_OFFSET  = 8'h14;
   localparam logic [7:0] SPAN_GAIN_OFFSET   = 8'h18;
   localparam logic [7:0] READING_OFFSET     = 8'h1C;

   // Status register field positions
   localparam int unsigned ST_UPPER_BIT      = 0;
   localparam int unsigned ST_LOWER_BIT      = 1;
   localparam int unsigned ST_FAIL_BIT       = 2;
   localparam int unsigned ST_INHIBIT_BIT    = 3;
   localparam int unsigned ST_WIDE_BIT       = 4;
   localparam int unsigned ST_ANALYZE_BIT    = 5;
   localparam int unsigned ST_FUNC_LSB       = 8;

   typedef enum logic [1:0] {mode_auto, mode_narrow, mode_wide} range_mode_type;

   typedef enum logic [2:0] {
      func_none, func_upper, func_lower, func_wide, func_narrow, func_mode, func_span
   } function_type;

endpackage

//--- verilog/oxygen_alarm_range_control.sv
// Purpose: Alarm, range and analog output control for a percent oxygen analyzer.
// Assumes: Reading and buttons are synchronous to pclk and already debounced.
// Notes:   Setpoints are reachable from the panel buttons and over APB.
// Functional notes
// - Voltage output 0 V to 10 V at full scale
// - Range_identity_output shows narrow, wide, air cal levels
// - Loop output 4 mA to 20 mA at full scale
// - Relays energized while alarm is inactive
// - Upper alarm above setpoint, set 1 to 25 %
// - Lower alarm when reading below setpoint
// - Setpoints absolute, compared regardless of range
// - Below 0.05 % raise sensor fail, blink
// - No button pressed for 5 s means analyze mode
// - Function or span button enters setup anytime
// - Up raises, down lowers the selected value
// - Both full scales adjustable 1 to 25 %
// - Autorange up at narrow full scale
// - Autorange down at 85 % of narrow
// - Auto, fixed narrow, fixed wide range modes
// - Alarms suppressed during span and 25 s after span ends
`timescale 1ns/1ps
`default_nettype none
module oxygen_alarm_range_control
   import oxygen_control_pkg::*;
#(
   parameter int unsigned WINDOW_CYCLES  = ADJUST_WINDOW_CYC,
   parameter int unsigned INHIBIT_CYCLES = ALARM_INHIBIT_CYC,
   parameter int unsigned BLINK_CYCLES   = BLINK_HALF_CYC
)
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Converter reading, hundredths of a percent
   input  wire logic [11:0] raw_reading,
   // Front panel buttons, high while pressed
   input  wire logic        upper_alarm_setup_button,
   input  wire logic        lower_alarm_setup_button,
   input  wire logic        wide_range_setup_button,
   input  wire logic        narrow_range_setup_button,
   input  wire logic        span_button,
   input  wire logic        up_button,
   input  wire logic        down_button,
   // Relays, high means coil energized
   output logic             upper_alarm_relay,
   output logic             lower_alarm_relay,
   output logic             sensor_fail_relay,
   // Indicators and display
   output logic             alarm_indicator,
   output logic             analyze_mode,
   output logic [11:0]      display_value,
   // Analog output DAC codes
   output logic [11:0]      concentration_voltage_code,
   output logic [11:0]      concentration_current_code,
   output logic [11:0]      range_identity_output
);
   // Stored settings and state
   logic [11:0]    upper_alarm;
   logic [11:0]    lower_alarm;
   logic [11:0]    wide_range_fs;
   logic [11:0]    narrow_range_fs;
   logic [11:0]    span_gain;
   range_mode_type range_mode;
   function_type   active_function;
   logic           wide_range;
   logic [31:0]    window_count;
   logic [31:0]    inhibit_count;
   logic [31:0]    blink_count;
   logic           blink_phase;
   logic [6:0]     buttons_prev;
   logic [11:0]    reading;
   // Button edges; the previous sample is a plain register, inputs are already synchronous
   wire [6:0] buttons_now = {up_button, down_button, span_button, narrow_range_setup_button,
                             wide_range_setup_button, lower_alarm_setup_button,
                             upper_alarm_setup_button};
   wire [6:0] button_rise = buttons_now & ~buttons_prev;
   wire       up_step     = button_rise[6];
   wire       down_step   = button_rise[5];
   wire       any_function_held = |buttons_now[4:0];
   wire       range_pair_held   = narrow_range_setup_button & wide_range_setup_button;
   // New function chosen on any function button press, the range pair taking priority
   function_type pressed_function;
   always_comb
   begin
      pressed_function = func_none;
      if (range_pair_held && (button_rise[3] || button_rise[2]))
         pressed_function = func_mode;
      else if (button_rise[0])
         pressed_function = func_upper;
      else if (button_rise[1])
         pressed_function = func_lower;
      else if (button_rise[2])
         pressed_function = func_wide;
      else if (button_rise[3])
         pressed_function = func_narrow;
      else if (button_rise[4])
         pressed_function = func_span;
   end
   // Span gain correction of the converter reading
   wire [23:0] gained_reading = raw_reading * span_gain;
   wire [12:0] corrected_wide = 13'(gained_reading >> SPAN_SHIFT);
   wire [11:0] next_reading   = (corrected_wide > 13'(DAC_FULL)) ? DAC_FULL
                                                                  : corrected_wide[11:0];
   // Window timing: held functions keep the window open, steps restart it
   wire step_event    = (active_function != func_none) && (up_step || down_step);
   wire window_reload = (pressed_function != func_none) || step_event || any_function_held;
   wire window_expire = (active_function != func_none) && (window_count == 32'h0000_0000);
   wire span_leaving  = (active_function == func_span) && window_expire;
   // Clamped step of the selected setpoint
   function automatic logic [11:0] stepped(input logic [11:0] value,
                                           input logic        up,
                                           input logic        down);
      logic [11:0] result;
      result = value;
      if (up && value < CONC_MAX_SET)
         result = value + 12'h001;
      else if (down && value > CONC_MIN_SET)
         result = value - 12'h001;
      return result;
   endfunction
   // Bus write values clamped to the same limits as the panel
   function automatic logic [11:0] clamped(input logic [31:0] value);
      logic [11:0] result;
      result = value[11:0];
      if (value > 32'(CONC_MAX_SET))
         result = CONC_MAX_SET;
      else if (value < 32'(CONC_MIN_SET))
         result = CONC_MIN_SET;
      return result;
   endfunction
   // APB decode; one wait state so read data comes from a register
   wire access_phase = psel && penable;
   wire bus_write    = access_phase && pready && pwrite;
   wire addr_known   = (paddr[7:5] == 3'b000) && (paddr[1:0] == 2'b00);
   wire wr_upper     = bus_write && paddr == UPPER_ALARM_OFFSET;
   wire wr_lower     = bus_write && paddr == LOWER_ALARM_OFFSET;
   wire wr_wide      = bus_write && paddr == WIDE_FS_OFFSET;
   wire wr_narrow    = bus_write && paddr == NARROW_FS_OFFSET;
   wire wr_mode      = bus_write && paddr == RANGE_MODE_OFFSET;
   wire wr_span      = bus_write && paddr == SPAN_GAIN_OFFSET;
   wire step_up      = step_event && up_step;
   wire step_down    = step_event && down_step && !up_step;
   // Alarm decisions on the absolute reading, whatever range is active
   wire upper_active   = reading > upper_alarm;
   wire lower_active   = reading < lower_alarm;
   wire fail_active    = reading < SENSOR_FAIL_LEVEL;
   wire alarms_blocked = (inhibit_count != 32'h0000_0000) || (active_function == func_span);
   wire [31:0] status_word = {16'h0000, 5'h00, active_function, 2'b00,
                              (active_function == func_none), wide_range,
                              alarms_blocked, fail_active, lower_active, upper_active};
   logic [31:0] read_mux;
   always_comb
   begin
      unique case (paddr)
         STATUS_OFFSET:      read_mux = status_word;
         UPPER_ALARM_OFFSET: read_mux = {20'h00000, upper_alarm};
         LOWER_ALARM_OFFSET: read_mux = {20'h00000, lower_alarm};
         WIDE_FS_OFFSET:     read_mux = {20'h00000, wide_range_fs};
         NARROW_FS_OFFSET:   read_mux = {20'h00000, narrow_range_fs};
         RANGE_MODE_OFFSET:  read_mux = {30'h0000_0000, range_mode};
         SPAN_GAIN_OFFSET:   read_mux = {20'h00000, span_gain};
         READING_OFFSET:     read_mux = {20'h00000, reading};
         default:            read_mux = 32'h0000_0000;
      endcase
   end
   // Bus handshake registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= access_phase && !pready;
         pslverr <= access_phase && !pready && !addr_known;
         prdata  <= (access_phase && !pready && !pwrite) ? read_mux : 32'h0000_0000;
      end
   end
   // Range mode stepping on the panel
   function automatic range_mode_type mode_step(input range_mode_type mode, input logic up);
      range_mode_type result;
      unique case (mode)
         mode_auto:   result = up ? mode_narrow : mode_wide;
         mode_narrow: result = up ? mode_wide : mode_auto;
         mode_wide:   result = up ? mode_auto : mode_narrow;
         default:     result = mode_auto;
      endcase
      return result;
   endfunction
   // Settings; the panel wins over a bus write in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upper_alarm     <= UPPER_ALARM_RESET;
         lower_alarm     <= LOWER_ALARM_RESET;
         wide_range_fs   <= WIDE_FS_RESET;
         narrow_range_fs <= NARROW_FS_RESET;
         span_gain       <= SPAN_UNITY;
         range_mode      <= mode_auto;
      end
      else
      begin
         if (active_function == func_upper && step_event)
            upper_alarm <= stepped(upper_alarm, step_up, step_down);
         else if (wr_upper)
            upper_alarm <= clamped(pwdata);
         if (active_function == func_lower && step_event)
            lower_alarm <= stepped(lower_alarm, step_up, step_down);
         else if (wr_lower)
            lower_alarm <= clamped(pwdata);
         if (active_function == func_wide && step_event)
            wide_range_fs <= stepped(wide_range_fs, step_up, step_down);
         else if (wr_wide)
            wide_range_fs <= clamped(pwdata);
         if (active_function == func_narrow && step_event)
            narrow_range_fs <= stepped(narrow_range_fs, step_up, step_down);
         else if (wr_narrow)
            narrow_range_fs <= clamped(pwdata);
         if (active_function == func_mode && step_event)
            range_mode <= mode_step(range_mode, step_up);
         else if (wr_mode && pwdata[1:0] != 2'b11)
            range_mode <= range_mode_type'(pwdata[1:0]);
         if (active_function == func_span && step_event)
            span_gain <= step_up ? ((span_gain != DAC_FULL) ? span_gain + 12'h001 : span_gain)
                                 : ((span_gain != 12'h001) ? span_gain - 12'h001 : span_gain);
         else if (wr_span && pwdata[11:0] != 12'h000)
            span_gain <= pwdata[11:0];
      end
   end
   // Function selection and its window; expiry leaves values as they stand
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_function <= func_none;
         window_count    <= 32'h0000_0000;
         buttons_prev    <= 7'h00;
      end
      else
      begin
         buttons_prev <= buttons_now;
         if (pressed_function != func_none)
            active_function <= pressed_function;
         else if (window_expire && !any_function_held)
            active_function <= func_none;
         if (window_reload)
            window_count <= WINDOW_CYCLES - 1;
         else if (window_count != 32'h0000_0000)
            window_count <= window_count - 32'h0000_0001;
      end
   end
   // Alarm inhibit after calibration ends, and blink timebase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         inhibit_count <= 32'h0000_0000;
         blink_count   <= 32'h0000_0000;
         blink_phase   <= 1'b0;
      end
      else
      begin
         if (span_leaving || (pressed_function != func_none && active_function == func_span))
            inhibit_count <= INHIBIT_CYCLES;
         else if (inhibit_count != 32'h0000_0000)
            inhibit_count <= inhibit_count - 32'h0000_0001;
         if (blink_count >= BLINK_CYCLES - 1)
         begin
            blink_count <= 32'h0000_0000;
            blink_phase <= !blink_phase;
         end
         else
            blink_count <= blink_count + 32'h0000_0001;
      end
   end
   // Range selection with hysteresis in automatic mode
   wire [19:0] reading_scaled = reading * HUNDRED_PERCENT;
   wire [19:0] return_level   = narrow_range_fs * RETURN_PERCENT;
   logic next_wide_range;
   always_comb
   begin
      next_wide_range = wide_range;
      unique case (range_mode)
         mode_narrow: next_wide_range = 1'b0;
         mode_wide:   next_wide_range = 1'b1;
         default:
         begin
            if (!wide_range && reading >= narrow_range_fs)
               next_wide_range = 1'b1;
            else if (wide_range && reading_scaled <= return_level)
               next_wide_range = 1'b0;
         end
      endcase
   end
   // Output scaling against the active full scale
   wire [11:0] active_fs    = wide_range ? wide_range_fs : narrow_range_fs;
   wire [11:0] reading_cap  = (reading > active_fs) ? active_fs : reading;
   wire [23:0] volt_product = reading_cap * DAC_FULL;
   wire [23:0] loop_product = reading_cap * DAC_LOOP_SPAN;
   wire [11:0] next_voltage = 12'(volt_product / active_fs);
   wire [11:0] next_current = DAC_LOOP_ZERO + 12'(loop_product / active_fs);
   wire [11:0] next_range_identity_output = (active_function == func_span) ? RANGE_IDENTITY_OUTPUT_AIR_CAL
                             : (next_wide_range ? RANGE_IDENTITY_OUTPUT_WIDE : RANGE_IDENTITY_OUTPUT_NARROW);
   // Display shows the setpoint, full scale or range mode being set, else the reading
   logic [11:0] next_display;
   always_comb
   begin
      unique case (active_function)
         func_upper:  next_display = upper_alarm;
         func_lower:  next_display = lower_alarm;
         func_wide:   next_display = wide_range_fs;
         func_narrow: next_display = narrow_range_fs;
         func_mode:   next_display = {10'h000, range_mode};
         default:     next_display = reading;
      endcase
   end
   // Output registers; relays drop only when an alarm is active and not blocked
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reading                    <= 12'h000;
         wide_range                 <= 1'b0;
         upper_alarm_relay          <= 1'b1;
         lower_alarm_relay          <= 1'b1;
         sensor_fail_relay          <= 1'b1;
         alarm_indicator            <= 1'b0;
         analyze_mode               <= 1'b1;
         display_value              <= 12'h000;
         concentration_voltage_code <= 12'h000;
         concentration_current_code <= DAC_LOOP_ZERO;
         range_identity_output      <= RANGE_IDENTITY_OUTPUT_NARROW;
      end
      else
      begin
         reading                    <= next_reading;
         wide_range                 <= next_wide_range;
         upper_alarm_relay          <= !(upper_active && !alarms_blocked);
         lower_alarm_relay          <= !(lower_active && !alarms_blocked);
         sensor_fail_relay          <= !(fail_active && !alarms_blocked);
         alarm_indicator            <= fail_active && !alarms_blocked && blink_phase;
         analyze_mode               <= (active_function == func_none);
         display_value              <= next_display;
         concentration_voltage_code <= next_voltage;
         concentration_current_code <= next_current;
         range_identity_output      <= next_range_identity_output;
      end
   end
endmodule
`default_nettype wire

//--- sim/oxygen_control_monitor.sv
// Purpose: Port level checks for the oxygen alarm and range block.
// Assumes: Span gain stays at unity while these checks run.
// Notes:   Relays and codes lag the raw reading by two edges.
`timescale 1ns/1ps
`default_nettype none
module oxygen_control_monitor
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Inputs watched
   input wire logic [11:0] raw_reading,
   input wire logic        upper_alarm_setup_button,
   // Outputs watched
   input wire logic        upper_alarm_relay,
   input wire logic        lower_alarm_relay,
   input wire logic        sensor_fail_relay,
   input wire logic        analyze_mode,
   input wire logic [11:0] concentration_voltage_code,
   input wire logic [11:0] concentration_current_code,
   input wire logic [11:0] range_identity_output
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Zero held long enough to reach the output register
   sequence zero_in;
      raw_reading == 12'h000 [*3];
   endsequence
   chk_volt_zero: assert property (zero_in |-> concentration_voltage_code == 12'h000)
      else $error("voltage code not zero at zero reading");
   chk_loop_zero: assert property (zero_in |-> concentration_current_code == 12'h333)
      else $error("loop code not at 4 mA for zero reading");
   chk_loop_floor: assert property (concentration_current_code >= 12'h333)
      else $error("loop code below 4 mA");
   chk_range_level: assert property (range_identity_output inside {12'h555, 12'hAAA, 12'hFFF})
      else $error("range identity level illegal");
   // Released relay needs a cause; the guard skips stale pre-reset samples
   chk_upper_cause: assert property ($past(presetn, 2) && !upper_alarm_relay |-> $past(raw_reading, 2) > 12'h064)
      else $error("upper relay released without high reading");
   chk_lower_cause: assert property ($past(presetn, 2) && !lower_alarm_relay |-> $past(raw_reading, 2) < 12'h9C4)
      else $error("lower relay released without low reading");
   chk_fail_cause: assert property ($past(presetn, 2) && !sensor_fail_relay |-> $past(raw_reading, 2) < 12'h005)
      else $error("fail relay released above fail level");
   chk_setup_entry: assert property ($rose(upper_alarm_setup_button) |-> ##2 !analyze_mode)
      else $error("function press did not leave analyze mode");
endmodule
bind oxygen_alarm_range_control oxygen_control_monitor chk (.pclk(pclk), .presetn(presetn),
   .raw_reading(raw_reading), .upper_alarm_setup_button(upper_alarm_setup_button),
   .upper_alarm_relay(upper_alarm_relay), .lower_alarm_relay(lower_alarm_relay),
   .sensor_fail_relay(sensor_fail_relay), .analyze_mode(analyze_mode),
   .concentration_voltage_code(concentration_voltage_code),
   .concentration_current_code(concentration_current_code),
   .range_identity_output(range_identity_output));
`default_nettype wire

//--- sim/panel_operator.sv
// Purpose: Operator at the front panel buttons.
// Assumes: Buttons are clean levels, bits {down, up, span, narrow, wide, lower, upper}.
// Notes:   Steps follow a press at once, long before the window closes.
`timescale 1ns/1ps
`default_nettype none
module panel_operator
(
   // Clock
   input  wire logic pclk,
   // Buttons, high while pressed
   output logic [6:0] buttons
);
   initial buttons = 7'h00;
   // Function buttons change together just after an edge
   task hold(input logic [4:0] f);
      @(posedge pclk);
      buttons[4:0] <= f;
   endtask
   // Short pulse; a gap after it so each rising edge is seen alone
   task step(input logic up);
      @(posedge pclk);
      buttons[up ? 5 : 6] <= 1'b1;
      repeat (2) @(posedge pclk);
      buttons[6:5] <= 2'b00;
      repeat (3) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the oxygen alarm and range block.
// Assumes: Short window and inhibit counts; span gain left at unity.
// Notes:   Register reads are noted in a queue and judged by a watcher.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import oxygen_control_pkg::*;
   localparam int WIN = 50;
   localparam int INH = 80;
   logic        pclk, presetn, psel, penable, pwrite, lit;
   logic [7:0]  paddr;
   logic [31:0] pwdata, seed = 32'hCF1B2876;
   logic [11:0] raw_reading, vals [12], fs, cap;
   logic [32:0] notes [$];
   logic        wide_on = 1'b0;
   int          mismatches = 0, samples_checked = 0;
   wire [31:0]  prdata;
   wire [11:0]  disp, volt, loop, rid;
   wire [6:0]   btn;
   wire         pready, pslverr, up_rly, lo_rly, fail_rly, blink, analyze;
   always #20 pclk = ~pclk;
   panel_operator op (.pclk(pclk), .buttons(btn));
   oxygen_alarm_range_control #(.WINDOW_CYCLES(WIN), .INHIBIT_CYCLES(INH), .BLINK_CYCLES(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .raw_reading(raw_reading), .upper_alarm_setup_button(btn[0]),
      .lower_alarm_setup_button(btn[1]), .wide_range_setup_button(btn[2]),
      .narrow_range_setup_button(btn[3]), .span_button(btn[4]), .up_button(btn[5]),
      .down_button(btn[6]), .upper_alarm_relay(up_rly), .lower_alarm_relay(lo_rly),
      .sensor_fail_relay(fail_rly), .alarm_indicator(blink), .analyze_mode(analyze),
      .display_value(disp), .concentration_voltage_code(volt),
      .concentration_current_code(loop), .range_identity_output(rid));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task check(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Request held until the edge that samples pready high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      notes.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // Read data is judged at the very edge the master takes it
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, notes.pop_front());
   initial
   begin
      repeat (30000) @(posedge pclk);
      mismatches++;
      results;
   end
   initial
   begin
      pclk = 1'b0;
      {presetn, psel, penable, pwrite, paddr, pwdata} <= 44'h0;
      raw_reading <= 12'h5DC;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check({up_rly, lo_rly, fail_rly}, 3'b111);
      rd(UPPER_ALARM_OFFSET, 33'h7D0);
      rd(LOWER_ALARM_OFFSET, 33'h4B0);
      rd(WIDE_FS_OFFSET, 33'h9C4);
      rd(NARROW_FS_OFFSET, 33'h3E8);
      rd(RANGE_MODE_OFFSET, 33'h0);
      rd(8'h20, 33'h100000000);
      $display("test reset values done");
      vals = '{12'h834, 12'h3E8, 12'h353, 12'h352, 12'h3E7, 12'h3E8, 12'h000, 12'h5DC,
               0, 0, 0, 0};
      foreach (vals[i])
      begin
         seed = xs(seed);
         if (i > 7)
            vals[i] = 12'(5 + seed % 2496);
         @(posedge pclk);
         raw_reading <= vals[i];
         repeat (2) @(posedge pclk);
         lit = 1'b0;
         repeat (8) @(posedge pclk) lit |= blink;
         if (!wide_on && vals[i] >= 12'h3E8) wide_on = 1'b1;
         else if (wide_on && vals[i] * 100 <= 85000) wide_on = 1'b0;
         fs = wide_on ? 12'h9C4 : 12'h3E8;
         cap = vals[i] > fs ? fs : vals[i];
         check(up_rly, 33'(!(vals[i] > 12'h7D0)));
         check(lo_rly, 33'(!(vals[i] < 12'h4B0)));
         check(fail_rly, 33'(!(vals[i] < 12'h005)));
         check(lit, 33'(vals[i] < 12'h005));
         check(rid, wide_on ? 33'hAAA : 33'h555);
         check(volt, 33'(cap * 4095 / fs));
         check(loop, 33'(819 + cap * 3276 / fs));
         rd(STATUS_OFFSET, 33'({1'b1, wide_on, 1'b0, vals[i] < 12'h005, vals[i] < 12'h4B0,
            vals[i] > 12'h7D0}));
      end
      $display("test alarms and ranges done");
      op.hold(5'h01);
      repeat (3) op.step(1'b1);
      check(analyze, 33'h0);
      check(disp, 33'h7D3);
      op.hold(5'h00);
      repeat (WIN + 10) @(posedge pclk);
      check(analyze, 33'h1);
      rd(UPPER_ALARM_OFFSET, 33'h7D3);
      // Lowest lower setpoint below the upper one
      apb(1'b1, LOWER_ALARM_OFFSET, 32'h064);
      op.hold(5'h02);
      op.hold(5'h00);
      repeat (WIN + 10) @(posedge pclk);
      check(analyze, 33'h1);
      op.hold(5'h02);
      op.step(1'b0);
      op.hold(5'h04);
      repeat (2) op.step(1'b1);
      op.hold(5'h0C);
      for (int m = 1; m < 4; m++)
      begin
         op.step(1'b1);
         rd(RANGE_MODE_OFFSET, 33'(m % 3));
      end
      op.hold(5'h00);
      rd(LOWER_ALARM_OFFSET, 33'h064);
      // Wide full scale holds at its 25.00 % ceiling
      rd(WIDE_FS_OFFSET, 33'h9C4);
      $display("test panel functions done");
      raw_reading <= 12'h960;
      op.hold(5'h10);
      repeat (4) @(posedge pclk);
      check(rid, 33'hFFF);
      op.hold(5'h00);
      repeat (20) @(posedge pclk);
      check(up_rly, 33'h1);
      repeat (WIN) @(posedge pclk);
      check(up_rly, 33'h1);
      repeat (INH) @(posedge pclk);
      check(up_rly, 33'h0);
      $display("test span inhibit done");
      results;
   end
endmodule
`default_nettype wire
